// file: hdl/scd_pkg.sv
`default_nettype none
package scd_pkg;

  // ----------------------------------------
  // Word layout, index 0 is the first bit in
  // ----------------------------------------
  localparam int WORD_BITS = 13;
  localparam int IDX_PRE0 = 0;
  localparam int IDX_PRE1 = 1;
  localparam int IDX_EN = 2;
  localparam int IDX_SGL = 3;
  localparam int IDX_SWAP = 4;
  localparam int IDX_ADDR_HI = 5;
  localparam int IDX_ADDR_LO = 6;
  localparam int IDX_PAIR = 7;
  localparam int IDX_EN2 = 8;
  localparam int IDX_TEMP = 9;
  localparam int IDX_REJ_A = 10;
  localparam int IDX_REJ_B = 11;
  localparam int IDX_DBL = 12;

  localparam logic [2:0] HDR_LOAD = 3'h5;
  localparam logic [5:0] FALLS_CHANNEL = 6'h08;
  localparam logic [5:0] FALLS_CONFIG = 6'h10;
  localparam logic [5:0] FALLS_LAST = 6'h20;

  // ----------------------------------------
  // Input selection codes, 4 is the shared return
  // ----------------------------------------
  localparam logic [2:0] IN_CH0 = 3'h0;
  localparam logic [2:0] IN_CH1 = 3'h1;
  localparam logic [2:0] IN_CH2 = 3'h2;
  localparam logic [2:0] IN_CH3 = 3'h3;
  localparam logic [2:0] IN_RET = 3'h4;

  localparam logic [1:0] REJ_BOTH = 2'h0;
  localparam logic [1:0] REJ_50 = 2'h1;
  localparam logic [1:0] REJ_60 = 2'h2;

  typedef struct packed {
    logic single_ended_select;
    logic swap;
    logic upper_addr_bit_hi;
    logic upper_addr_bit_lo;
    logic pair_select_bit;
  } scd_mux_t;

  typedef struct packed {
    logic temp_sensor_select;
    logic reject_sel_first;
    logic reject_sel_second;
    logic double_rate_select;
  } scd_cfg_t;

  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] neg;
    logic temp;
    logic [1:0] reject;
    logic double_rate;
    logic autocal;
  } scd_set_t;

  localparam scd_mux_t MUX_RESET = 5'h00;
  localparam scd_cfg_t CFG_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_CONV = 2'h0,
    ST_SLEEP = 2'h1,
    ST_IO = 2'h3
  } scd_state_t;

endpackage

`default_nettype wire

// file: hdl/scd_config_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module scd_config_decoder
  import scd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_conv_done,
  output logic o_conv_start,
  output logic o_result_ready,
  output logic o_in_io,
  output scd_set_t o_settings
);

  // ----------------------------------------
  // Channel map
  // ----------------------------------------
  function automatic scd_set_t decode(input scd_mux_t m, input scd_cfg_t c);
    scd_set_t s;
    logic [2:0] lo;
    logic [2:0] hi;
    s = '0;
    lo = m.pair_select_bit ? IN_CH2 : IN_CH0;
    hi = m.pair_select_bit ? IN_CH3 : IN_CH1;
    if (m.single_ended_select) begin
      s.pos = m.swap ? hi : lo;
      s.neg = IN_RET;
    end else begin
      s.pos = m.swap ? hi : lo;
      s.neg = m.swap ? lo : hi;
    end
    s.temp = c.temp_sensor_select;
    // First bit lands on the high side so 01 reads as the 50Hz-only code
    s.reject = {c.reject_sel_first, c.reject_sel_second};
    // Sensor runs are always 1x; 2x also lets the sign bit wobble at zero
    s.double_rate = c.double_rate_select & ~c.temp_sensor_select;
    s.autocal = ~s.double_rate;
    return s;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sck_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic sck_last_reg;
  logic cs_last_reg;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      sdi_sync_reg <= 2'h0;
      sck_last_reg <= 1'h0;
      cs_last_reg <= 1'h1;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], i_sck};
      cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
      sdi_sync_reg <= {sdi_sync_reg[0], i_sdi};
      sck_last_reg <= sck_sync_reg[1];
      cs_last_reg <= cs_sync_reg[1];
    end
  end

  wire sck_s = sck_sync_reg[1];
  wire cs_s = cs_sync_reg[1];
  wire sdi_s = sdi_sync_reg[1];
  wire sck_rise = sck_s & ~sck_last_reg;
  wire sck_fall = ~sck_s & sck_last_reg;
  wire cs_rise = cs_s & ~cs_last_reg;

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  scd_state_t state_reg;
  scd_state_t state_next;
  logic [WORD_BITS-1:0] bits_reg;
  logic [3:0] rx_cnt_reg;
  logic [5:0] fall_cnt_reg;
  logic boot_reg;
  scd_mux_t mux_reg;
  scd_cfg_t cfg_reg;

  wire in_sleep = (state_reg == ST_SLEEP);
  wire in_io = (state_reg == ST_IO);

  // Bits arrive only with select low, first edge opens the cycle
  wire take_bit = sck_rise & ~cs_s & (in_sleep | in_io)
    & (rx_cnt_reg < 4'(WORD_BITS));

  wire [5:0] falls_now = fall_cnt_reg + {5'h00, sck_fall & in_io};

  // Cycle ends at the last falling edge or on an early select release
  wire finish = in_io & (cs_rise
    | (sck_fall & (falls_now == FALLS_LAST)));

  // ----------------------------------------
  // Word decode
  // ----------------------------------------
  wire [2:0] header = {bits_reg[IDX_PRE0], bits_reg[IDX_PRE1],
    bits_reg[IDX_EN]};

  // Header other than 101 leaves both groups untouched
  wire hdr_load = (header == HDR_LOAD);

  wire ch_ok = hdr_load & (falls_now >= FALLS_CHANNEL);

  // Config needs the full word plus its own enable bit
  wire cfg_ok = ch_ok & bits_reg[IDX_EN2]
    & (falls_now >= FALLS_CONFIG);

  wire scd_mux_t mux_word = {bits_reg[IDX_SGL], bits_reg[IDX_SWAP],
    bits_reg[IDX_ADDR_HI], bits_reg[IDX_ADDR_LO],
    bits_reg[IDX_PAIR]};

  wire scd_cfg_t cfg_word = {bits_reg[IDX_TEMP], bits_reg[IDX_REJ_A],
    bits_reg[IDX_REJ_B], bits_reg[IDX_DBL]};

  // Upper address bits are stored but unused; host keeps them zero
  wire scd_mux_t mux_next = ch_ok ? mux_word : mux_reg;
  wire scd_cfg_t cfg_next = cfg_ok ? cfg_word : cfg_reg;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_CONV: begin
        // Words are ignored until the running conversion ends
        if (i_conv_done) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (take_bit) begin
          state_next = ST_IO;
        end
      end
      ST_IO: begin
        if (finish) begin
          state_next = ST_CONV;
        end
      end
      default: begin
        state_next = ST_CONV;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_CONV;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Shift capture
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      bits_reg <= '0;
      rx_cnt_reg <= 4'h0;
      fall_cnt_reg <= 6'h00;
    end else if (state_next != ST_IO && !take_bit) begin
      bits_reg <= '0;
      rx_cnt_reg <= 4'h0;
      fall_cnt_reg <= 6'h00;
    end else begin
      if (take_bit) begin
        bits_reg[rx_cnt_reg] <= sdi_s;
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
      if (sck_fall && in_io) begin
        fall_cnt_reg <= falls_now;
      end
    end
  end

  // ----------------------------------------
  // Stored settings
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mux_reg <= MUX_RESET;
      cfg_reg <= CFG_RESET;
    end else if (finish) begin
      mux_reg <= mux_next;
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------
  // Conversion hand-off
  // ----------------------------------------
  // Settings move only with a conversion start, never mid-conversion
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_reg <= 1'h1;
      o_conv_start <= 1'h0;
      o_settings <= '0;
    end else begin
      boot_reg <= 1'h0;
      o_conv_start <= boot_reg | finish;
      if (boot_reg) begin
        o_settings <= decode(MUX_RESET, CFG_RESET);
      end else if (finish) begin
        o_settings <= decode(mux_next, cfg_next);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_result_ready <= 1'h0;
      o_in_io <= 1'h0;
    end else begin
      o_result_ready <= (state_next != ST_CONV);
      o_in_io <= (state_next == ST_IO);
    end
  end

endmodule

`default_nettype wire

// file: sim/scd_sva.sv
`timescale 1ns/1ps
`default_nettype none
module scd_sva
  import scd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_conv_done,
  input wire logic o_conv_start,
  input wire logic o_result_ready,
  input wire logic o_in_io,
  input wire scd_set_t o_settings
);
  wire logic pair_ok = o_settings.pos <= IN_CH3 &&
    (o_settings.neg == IN_RET || o_settings.neg == (o_settings.pos ^ 3'h1));
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
    else $error("start pulse too long");
  a_set_hold: assert property (!o_conv_start |-> $stable(o_settings))
    else $error("settings moved without start");
  a_pair_ok: assert property (o_conv_start |-> pair_ok)
    else $error("illegal input pair");
  a_rate_cal: assert property (o_conv_start |-> o_settings.autocal != o_settings.double_rate)
    else $error("rate and calibration disagree");
  a_temp_slow: assert property (o_conv_start && o_settings.temp |-> !o_settings.double_rate)
    else $error("temperature run at double rate");
  a_ready_src: assert property ($rose(o_result_ready) |-> $past(i_conv_done))
    else $error("ready without conversion done");
  a_busy_conv: assert property (o_conv_start |-> !o_result_ready && !o_in_io)
    else $error("start while ready or in transfer");
  a_io_end: assert property ($fell(o_in_io) |-> o_conv_start)
    else $error("transfer ended without start");
  c_io: cover property ($fell(o_in_io));
  c_temp: cover property (o_conv_start && o_settings.temp);
  c_single: cover property (o_conv_start && o_settings.neg == IN_RET);
endmodule
bind scd_config_decoder scd_sva u_sva (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sck(i_sck),
  .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_conv_done(i_conv_done), .o_conv_start(o_conv_start),
  .o_result_ready(o_result_ready), .o_in_io(o_in_io), .o_settings(o_settings));
`default_nettype wire

// file: sim/scd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scd_host_model (
  input wire logic i_go,
  input wire logic [12:0] i_word,
  input wire logic [5:0] i_falls,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_sdi,
  output logic o_busy
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    o_busy = 1'b0;
  end
  // Odd offset keeps link edges away from the system clock edges
  always @(posedge i_go) begin
    o_busy = 1'b1;
    #37 o_cs_n = 1'b0;
    for (int i = 0; i < i_falls; i++) begin
      o_sdi = (i < 13) ? i_word[i] : ~o_sdi;
      #400 o_sck = 1'b1;
      #400 o_sck = 1'b0;
    end
    #200 o_cs_n = 1'b1;
    // Deselected line must not look like the last bit
    o_sdi = ~o_sdi;
    #300 o_busy = 1'b0;
  end
endmodule
`default_nettype wire

// file: sim/scd_config_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module scd_config_decoder_tb_top
  import scd_pkg::*;
;
  localparam scd_set_t DEF = '{3'h0, 3'h1, 1'b0, REJ_BOTH, 1'b0, 1'b1};
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_conv_done = 1'b0;
  logic go = 1'b0;
  logic [12:0] word = 13'h0000;
  logic [5:0] falls = 6'h00;
  wire logic sck, cs_n, sdi, busy, start, ready, in_io;
  wire scd_set_t set;
  scd_set_t exp_set;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [12:0] cw [7] = '{13'h1995, 13'h1995, 13'h179D, 13'h179D, 13'h1995, 13'h1FF8, 13'h1FF9};
  int cn [7] = '{7, 8, 15, 16, 32, 32, 32};
  always #50 i_mclk = ~i_mclk;
  scd_host_model u_host (.i_go(go), .i_word(word), .i_falls(falls), .o_sck(sck),
    .o_cs_n(cs_n), .o_sdi(sdi), .o_busy(busy));
  scd_config_decoder u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sck(sck), .i_cs_n(cs_n),
    .i_sdi(sdi), .i_conv_done(i_conv_done), .o_conv_start(start), .o_result_ready(ready),
    .o_in_io(in_io), .o_settings(set));
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic check(input logic [10:0] seen, input logic [10:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  function automatic scd_set_t predict(scd_set_t s, logic [12:0] w, int n);
    scd_set_t r;
    r = s;
    if (w[2:0] == HDR_LOAD && n >= 8) begin
      r.pos = {1'b0, w[IDX_PAIR], w[IDX_SWAP]};
      r.neg = w[IDX_SGL] ? IN_RET : {1'b0, w[IDX_PAIR], ~w[IDX_SWAP]};
      if (w[IDX_EN2] && n >= 16) begin
        r.temp = w[IDX_TEMP];
        r.reject = {w[IDX_REJ_A], w[IDX_REJ_B]};
        r.double_rate = w[IDX_DBL] & ~w[IDX_TEMP];
        r.autocal = ~r.double_rate;
      end
    end
    return r;
  endfunction
  function automatic logic [12:0] rand_word();
    logic [12:0] w;
    int r;
    w = 13'($urandom);
    r = int'($urandom % 4);
    w[6:5] = 2'h0;
    if (w[IDX_REJ_B]) w[IDX_REJ_A] = 1'b0;
    w[2:0] = (r == 0) ? 3'h0 : (r == 1) ? 3'h1 : HDR_LOAD;
    return w;
  endfunction
  task automatic frame(input logic [12:0] w, input int n, input logic live);
    int k;
    logic io_seen;
    i_conv_done <= live;
    @(posedge i_mclk);
    i_conv_done <= 1'b0;
    @(posedge i_mclk);
    word <= w;
    falls <= 6'(n);
    go <= 1'b1;
    if (live) exp_set = predict(exp_set, w, n);
    @(posedge i_mclk);
    go <= 1'b0;
    k = 0;
    io_seen = 1'b0;
    #1;
    check(11'(ready), 11'(live));
    while (!start && k < 400) begin
      @(posedge i_mclk);
      #1;
      if (in_io) io_seen = 1'b1;
      k++;
    end
    check(11'(start), 11'(live));
    check(11'(io_seen), 11'(live));
    check(11'({ready, in_io}), 11'h000);
    check(set, exp_set);
    while (busy) @(posedge i_mclk);
  endtask
  task automatic do_reset();
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    exp_set = DEF;
    @(posedge i_mclk);
    #1;
    check(11'(start), 11'h001);
    check(set, exp_set);
    check(11'({ready, in_io}), 11'h000);
  endtask
  initial begin
    void'($urandom(8237));
    do_reset();
    frame(13'h0185, 32, 1'b0);
    foreach (cw[i]) frame(cw[i], cn[i], 1'b1);
    for (int i = 0; i < 30; i++) frame(rand_word(), int'(1 + $urandom % 32), 1'b1);
    do_reset();
    frame(cw[2], 32, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
